// ==== common/byte_fifo_if.sv ====
`timescale 1ns/100ps
interface byte_fifo_if #(parameter int WIDTH = 8);
  logic push_valid;
  logic push_ready;
  logic [WIDTH-1:0] push_data;
  logic pop_valid;
  logic pop_ready;
  logic [WIDTH-1:0] pop_data;
  modport producer (output push_valid, output push_data, input push_ready,
    input pop_valid, input pop_data, output pop_ready);
  modport buffer (input push_valid, input push_data, output push_ready,
    output pop_valid, output pop_data, input pop_ready);
endinterface : byte_fifo_if

// ==== common/kbd_rx_defs.svh ====
`ifndef KBD_RX_DEFS_SVH
`define KBD_RX_DEFS_SVH

`define KBD_ADDR_CLEAR_SHIFT 24'hFE01C1
`define KBD_ADDR_SCAN_BYTE 24'hFE01C3
`define KBD_CLK_HZ 250000000
`define KBD_OSC_HZ 3686400
`define KBD_SAMPLE_DIV 2
`define KBD_PHASE_BITS 24
`define KBD_SYNC_STAGES 2
`define KBD_FIFO_DEPTH 16
`define KBD_DONE_RESET 1'b1
`define KBD_EMPTY_BYTE 8'h00

`endif

// ==== common/kbd_rx_pkg.sv ====
package kbd_rx_pkg;
  typedef logic [7:0] kbd_byte_t;
endpackage : kbd_rx_pkg

// ==== src/byte_fifo.sv ====
`timescale 1ns/100ps
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clock_i,
  input wire logic rst_i,
  byte_fifo_if.buffer port
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr_reg;
  logic [AW:0] rd_ptr_reg;
  logic full;
  logic empty;

  assign empty = (wr_ptr_reg == rd_ptr_reg);
  assign full = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) && (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
  assign port.push_ready = !full;
  assign port.pop_valid = !empty;
  assign port.pop_data = mem[rd_ptr_reg[AW-1:0]];

  always_ff @(posedge clock_i) begin
    if (port.push_valid && !full) begin
      mem[wr_ptr_reg[AW-1:0]] <= port.push_data;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      wr_ptr_reg <= '0;
    end else if (port.push_valid && !full) begin
      wr_ptr_reg <= wr_ptr_reg + 1'b1;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      rd_ptr_reg <= '0;
    end else if (port.pop_ready && !empty) begin
      rd_ptr_reg <= rd_ptr_reg + 1'b1;
    end
  end

  chk_fifo_no_overrun: assert property (@(posedge clock_i) disable iff (rst_i)
    full && !(port.pop_ready && !empty) |=> $stable(wr_ptr_reg))
    else $error("fifo pointer moved while full");
endmodule : byte_fifo

// ==== src/clock_sampler.sv ====
`timescale 1ns/100ps
`include "kbd_rx_defs.svh"
module clock_sampler (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic sample_en_i,
  input wire logic line_low_i,
  output logic strobe_o
);
  logic [`KBD_SYNC_STAGES-1:0] stage_reg;
  logic last_reg;

  // Reset empties every stage so no stale low pulse shifts after reset
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      stage_reg <= '0;
    end else if (sample_en_i) begin
      stage_reg <= {stage_reg[`KBD_SYNC_STAGES-2:0], line_low_i};
    end
  end

  // Edge taken from the last stage only, first stage feeds nothing else
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      last_reg <= 1'b0;
      strobe_o <= 1'b0;
    end else begin
      last_reg <= stage_reg[`KBD_SYNC_STAGES-1];
      strobe_o <= stage_reg[`KBD_SYNC_STAGES-1] && !last_reg;
    end
  end
endmodule : clock_sampler

// ==== src/pc_keyboard_receiver.sv ====
`timescale 1ns/100ps
`include "kbd_rx_defs.svh"
module pc_keyboard_receiver (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic kbd_clk_i,
  output logic kbd_clk_o,
  output logic kbd_clk_oe_o,
  input wire logic kbd_data_i,
  output logic kbd_data_o,
  output logic kbd_data_oe_o,
  output logic buffered_system_reset_o,
  input wire logic keyboard_select_strobe_i,
  input wire logic buffered_addr_bit0_i,
  output kbd_rx_pkg::kbd_byte_t rd_data_o,
  output logic rd_valid_o,
  output logic irq_n_o,
  output logic uart_input_port_bit_o,
  output logic overflow_o
);
  import kbd_rx_pkg::*;

  localparam logic [`KBD_PHASE_BITS-1:0] PHASE_INC =
    `KBD_PHASE_BITS'((64'(`KBD_OSC_HZ) << `KBD_PHASE_BITS) / 64'(`KBD_CLK_HZ));
  localparam int SAMPLE_HZ = `KBD_OSC_HZ / `KBD_SAMPLE_DIV;
  localparam int SAMPLE_CYCLES_MIN = `KBD_CLK_HZ / SAMPLE_HZ;
  localparam int SAMPLE_CYCLES_MAX = SAMPLE_CYCLES_MIN + 1;

  //////////////////////////////////////////////////////////////////////////
  // Oscillator and sample clock enables

  logic [`KBD_PHASE_BITS:0] phase_next;
  logic [`KBD_PHASE_BITS-1:0] phase_reg;
  logic osc_tick;
  logic half_reg;
  logic sample_en_reg;

  // Fractional accumulator stands in for the oscillator, increment truncated so average rate runs slightly low
  assign phase_next = {1'b0, phase_reg} + {1'b0, PHASE_INC};
  assign osc_tick = phase_next[`KBD_PHASE_BITS];

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      phase_reg <= '0;
    end else begin
      phase_reg <= phase_next[`KBD_PHASE_BITS-1:0];
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      half_reg <= 1'b0;
      sample_en_reg <= 1'b0;
    end else begin
      if (osc_tick) begin
        half_reg <= !half_reg;
      end
      sample_en_reg <= osc_tick && half_reg;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Clock line synchroniser

  logic strobe;

  clock_sampler u_sampler (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .sample_en_i(sample_en_reg),
    .line_low_i(!kbd_clk_i),
    .strobe_o(strobe)
  );

  //////////////////////////////////////////////////////////////////////////
  // Host read decode

  logic read_byte;
  logic read_clear;

  assign read_byte = keyboard_select_strobe_i && buffered_addr_bit0_i;
  assign read_clear = keyboard_select_strobe_i && !buffered_addr_bit0_i;

  //////////////////////////////////////////////////////////////////////////
  // Shift register and frame detection

  byte_fifo_if #(.WIDTH(8)) fifo_port ();

  kbd_byte_t shift_reg;
  kbd_byte_t shift_next;
  logic done_reg;
  logic last_stage_serial_out;
  logic frame_end;
  logic shift_go;
  logic stalled;

  // Stage 7 is the first stage, stage 0 the last
  assign last_stage_serial_out = shift_reg[0];
  assign shift_next = {kbd_data_i, shift_reg[7:1]};
  // A full buffer holds the start bit back instead of losing a byte
  assign stalled = last_stage_serial_out && !fifo_port.push_ready;
  assign shift_go = strobe && !done_reg && !stalled;
  assign frame_end = shift_go && last_stage_serial_out;

  // Clearing the register wins over a strobe in the same cycle
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      shift_reg <= '0;
    end else if (read_clear) begin
      shift_reg <= '0;
    end else if (shift_go) begin
      shift_reg <= shift_next;
    end
  end

  // Done comes up set so nothing shifts until software first reads
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      done_reg <= `KBD_DONE_RESET;
    end else if (frame_end) begin
      done_reg <= 1'b1;
    end else if (read_byte) begin
      done_reg <= 1'b0;
    end
  end // Held otherwise

  assign fifo_port.push_valid = frame_end;
  assign fifo_port.push_data = shift_next;
  assign fifo_port.pop_ready = read_byte;

  byte_fifo #(
    .WIDTH(8),
    .DEPTH(`KBD_FIFO_DEPTH)
  ) u_fifo (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .port(fifo_port)
  );

  //////////////////////////////////////////////////////////////////////////
  // Read data

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      rd_data_o <= `KBD_EMPTY_BYTE;
      rd_valid_o <= 1'b0;
    end else begin
      rd_valid_o <= keyboard_select_strobe_i;
      if (read_byte) begin
        rd_data_o <= fifo_port.pop_valid ? fifo_port.pop_data : `KBD_EMPTY_BYTE;
      end else if (read_clear) begin
        rd_data_o <= `KBD_EMPTY_BYTE;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Pins and interrupt request

  logic done_next;

  assign done_next = frame_end || (done_reg && !read_byte);

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      buffered_system_reset_o <= 1'b1;
      kbd_clk_o <= 1'b0;
      kbd_clk_oe_o <= 1'b1;
    end else begin
      buffered_system_reset_o <= 1'b0;
      kbd_clk_o <= 1'b0;
      kbd_clk_oe_o <= 1'b0;
    end
  end

  // Driven from the next value so pins track the flag with no lag
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      kbd_data_o <= 1'b0;
      kbd_data_oe_o <= `KBD_DONE_RESET;
      irq_n_o <= !`KBD_DONE_RESET;
      uart_input_port_bit_o <= !`KBD_DONE_RESET;
    end else begin
      kbd_data_o <= 1'b0;
      kbd_data_oe_o <= done_next;
      irq_n_o <= !done_next;
      uart_input_port_bit_o <= !done_next;
    end
  end

  // Sticky until reset; set only when a frame met a full buffer
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      overflow_o <= 1'b0;
    end else if (strobe && !done_reg && stalled) begin
      overflow_o <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Checks

  int unsigned gap_count;
  logic seen_sample_reg;

  always_ff @(posedge clock_i) begin
    if (rst_i || sample_en_reg) begin
      gap_count <= 0;
    end else begin
      gap_count <= gap_count + 1;
    end
  end

  // The first spacing after reset is measured from release, so it is skipped
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      seen_sample_reg <= 1'b0;
    end else if (sample_en_reg) begin
      seen_sample_reg <= 1'b1;
    end
  end

  chk_reset_release: assert property (@(posedge clock_i) disable iff (rst_i)
    $past(rst_i) |-> kbd_clk_oe_o && !kbd_clk_o && buffered_system_reset_o)
    else $error("keyboard clock not held low through reset");

  chk_sync_cleared: assert property (@(posedge clock_i) disable iff (rst_i)
    $past(rst_i) |-> !strobe ##1 !strobe)
    else $error("strobe right after reset");

  chk_sample_gap: assert property (@(posedge clock_i) disable iff (rst_i)
    sample_en_reg && seen_sample_reg |->
      gap_count + 1 >= SAMPLE_CYCLES_MIN
      && gap_count + 1 <= SAMPLE_CYCLES_MAX)
    else $error("sample enable spacing wrong");

  chk_shift_hold: assert property (@(posedge clock_i) disable iff (rst_i)
    done_reg && !read_clear |=> $stable(shift_reg))
    else $error("shift register moved while done");

  chk_shift_step: assert property (@(posedge clock_i) disable iff (rst_i)
    shift_go && !read_clear |=> shift_reg == {$past(kbd_data_i), $past(shift_reg[7:1])})
    else $error("shift step wrong");

  chk_done_sets: assert property (@(posedge clock_i) disable iff (rst_i)
    strobe && !done_reg && shift_reg[0] && fifo_port.push_ready |=> done_reg ##1 !irq_n_o)
    else $error("done not set by start bit");

  chk_irq_level: assert property (@(posedge clock_i) disable iff (rst_i)
    !$past(rst_i) |-> irq_n_o == !$past(done_next) && uart_input_port_bit_o == irq_n_o)
    else $error("interrupt request does not follow done");

  chk_done_holds: assert property (@(posedge clock_i) disable iff (rst_i)
    done_reg && !read_byte |=> done_reg)
    else $error("done dropped without read");

  chk_data_pull: assert property (@(posedge clock_i) disable iff (rst_i)
    kbd_data_oe_o == done_reg && !kbd_data_o)
    else $error("data line drive wrong");

  chk_read_byte: assert property (@(posedge clock_i) disable iff (rst_i)
    read_byte && !frame_end |=> !done_reg && rd_valid_o)
    else $error("byte read did not clear done");

  chk_clear_shift: assert property (@(posedge clock_i) disable iff (rst_i)
    read_clear |=> shift_reg == 8'h00 && rd_valid_o)
    else $error("clear read left shift register");

  chk_byte_capture: assert property (@(posedge clock_i) disable iff (rst_i)
    frame_end |=> shift_reg == $past(fifo_port.push_data) || $past(read_clear))
    else $error("captured byte differs from stages");

  cov_frame_done: cover property (@(posedge clock_i) disable iff (rst_i)
    frame_end);
  cov_byte_read: cover property (@(posedge clock_i) disable iff (rst_i)
    read_byte && fifo_port.pop_valid);
  cov_service: cover property (@(posedge clock_i) disable iff (rst_i)
    read_byte ##[1:1000] read_clear);
  cov_buffer_full: cover property (@(posedge clock_i) disable iff (rst_i)
    !fifo_port.push_ready);
endmodule : pc_keyboard_receiver

// ==== tb/kbd_model.sv ====
`timescale 1ns/100ps
module kbd_model (
  input wire logic clock_i,
  input wire logic clk_line_i,
  input wire logic data_line_i,
  input wire logic send_i,
  input wire logic force_i,
  input wire logic [7:0] code_i,
  output logic clk_low_o,
  output logic data_low_o,
  output logic busy_o
);
  logic [8:0] frame;
  int i;
  initial begin
    clk_low_o = 1'b0;
    data_low_o = 1'b0;
    busy_o = 1'b0;
    forever begin
      @(posedge clock_i);
      if (send_i === 1'b1) begin
        busy_o <= 1'b1;
        // One code per key event, start bit first, then LSB first
        frame = {code_i, 1'b1};
        // Held clock or held data inhibits sending until both lines are high, unless force_i is set
        while (!force_i && (data_line_i !== 1'b1 || clk_line_i !== 1'b1)) begin
          @(posedge clock_i);
        end
        for (i = 0; i < 9; i++) begin
          data_low_o <= ~frame[i];
          repeat (100) @(posedge clock_i);
          // One low clock pulse per bit, long enough for two samples
          clk_low_o <= 1'b1;
          repeat (400) @(posedge clock_i);
          clk_low_o <= 1'b0;
          repeat (300) @(posedge clock_i);
        end
        // Released line floats up to the pull-up level
        data_low_o <= 1'b0;
        busy_o <= 1'b0;
      end
    end
  end
endmodule : kbd_model

// ==== tb/pc_keyboard_receiver_tb.sv ====
`timescale 1ns/100ps
module pc_keyboard_receiver_tb;
  import kbd_rx_pkg::*;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic sel = 1'b0;
  logic a1 = 1'b0;
  logic send = 1'b0;
  logic force_tx = 1'b0;
  kbd_byte_t code = 8'h00;
  logic clk_oe, data_oe, kb_clk_low, kb_data_low, busy, rd_valid, irq_n, uart_bit, ovf, reset_o;
  logic clk_val, data_val;
  wire clk_line;
  wire data_line;
  kbd_byte_t rd_data, c, d;
  int miscompares = 0;
  int num_checks = 0;
  int i;
  kbd_byte_t expq[$];

  always #2 clock_i = ~clock_i;
  // Open-drain lines with pull-ups: low while either side pulls
  assign clk_line = ~(clk_oe | kb_clk_low);
  assign data_line = ~(data_oe | kb_data_low);

  pc_keyboard_receiver DUT (.clock_i(clock_i), .rst_i(rst_i), .kbd_clk_i(clk_line),
    .kbd_clk_o(clk_val), .kbd_clk_oe_o(clk_oe), .kbd_data_i(data_line), .kbd_data_o(data_val),
    .kbd_data_oe_o(data_oe), .buffered_system_reset_o(reset_o),
    .keyboard_select_strobe_i(sel), .buffered_addr_bit0_i(a1), .rd_data_o(rd_data),
    .rd_valid_o(rd_valid), .irq_n_o(irq_n), .uart_input_port_bit_o(uart_bit),
    .overflow_o(ovf));
  kbd_model keyboard (.clock_i(clock_i), .clk_line_i(clk_line), .data_line_i(data_line),
    .send_i(send), .force_i(force_tx), .code_i(code), .clk_low_o(kb_clk_low),
    .data_low_o(kb_data_low), .busy_o(busy));

  ////////////////////////////////////////////////////////////////////////////
  task automatic cmp_bit(logic got, logic exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp_bit

  task automatic cmp_byte(kbd_byte_t got, kbd_byte_t exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp_byte

  task conclude;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : conclude

  task automatic bounded(int k, int lim);
    if (k >= lim) begin
      miscompares++;
      conclude();
    end
  endtask : bounded

  task automatic host_read(logic addr_bit, output kbd_byte_t dat);
    int k;
    @(posedge clock_i);
    sel <= 1'b1;
    a1 <= addr_bit;
    @(posedge clock_i);
    sel <= 1'b0;
    #1;
    k = 0;
    while (rd_valid !== 1'b1 && k < 4) begin
      @(posedge clock_i);
      #1;
      k++;
    end
    bounded(k, 4);
    dat = rd_data;
  endtask : host_read

  task automatic wait_irq();
    int k;
    k = 0;
    while (irq_n !== 1'b0 && k < 2000) begin
      @(posedge clock_i);
      #1;
      k++;
    end
    bounded(k, 2000);
  endtask : wait_irq

  task automatic send_code(kbd_byte_t cv, logic f);
    int k;
    @(posedge clock_i);
    code <= cv;
    force_tx <= f;
    send <= 1'b1;
    @(posedge clock_i);
    send <= 1'b0;
    @(posedge clock_i);
    #1;
    k = 0;
    while (busy === 1'b1 && k < 20000) begin
      @(posedge clock_i);
      #1;
      k++;
    end
    bounded(k, 20000);
  endtask : send_code

  task automatic do_reset();
    @(posedge clock_i);
    rst_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    #1;
    cmp_bit(clk_oe, 1'b1);
    cmp_bit(clk_val, 1'b0);
    cmp_bit(reset_o, 1'b1);
    @(posedge clock_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    #1;
    cmp_bit(clk_oe, 1'b0);
    cmp_bit(reset_o, 1'b0);
    cmp_bit(irq_n, 1'b0);
    cmp_bit(data_oe, 1'b1);
    cmp_bit(data_val, 1'b0);
    // Software's first read after reset releases the keyboard
    host_read(1'b1, d);
    cmp_bit(data_oe, 1'b0);
    host_read(1'b0, d);
    cmp_byte(d, 8'h00);
  endtask : do_reset

  task automatic service();
    wait_irq();
    cmp_bit(data_oe, 1'b1);
    cmp_bit(uart_bit, 1'b0);
    host_read(1'b1, d);
    cmp_byte(d, expq.pop_front());
    cmp_bit(irq_n, 1'b1);
    cmp_bit(data_oe, 1'b0);
    host_read(1'b0, d);
    cmp_byte(d, 8'h00);
  endtask : service

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    i = $urandom(38159);
    do_reset();
    for (i = 0; i < 4; i++) begin
      c = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : kbd_byte_t'($urandom);
      expq.push_back(c);
      send_code(c, 1'b0);
      service();
    end
    // Keyboard forced to clock a second frame while the first is held
    c = kbd_byte_t'($urandom);
    expq.push_back(c);
    send_code(c, 1'b0);
    wait_irq();
    send_code(~c, 1'b1);
    cmp_bit(irq_n, 1'b0);
    host_read(1'b1, d);
    cmp_byte(d, expq.pop_front());
    host_read(1'b0, d);
    repeat (2000) @(posedge clock_i);
    #1;
    cmp_bit(irq_n, 1'b1);
    do_reset();
    c = kbd_byte_t'($urandom);
    expq.push_back(c);
    send_code(c, 1'b0);
    service();
    cmp_bit(ovf, 1'b0);
    conclude();
  end
endmodule : pc_keyboard_receiver_tb
